// file: include/npp_params.svh
`ifndef NPP_PARAMS_SVH
`define NPP_PARAMS_SVH

// NAND command codes
`define NPP_CMD_SETUP 8'h80
`define NPP_CMD_CONFIRM 8'h10
`define NPP_CMD_CACHE 8'h15
`define NPP_CMD_QUEUE 8'h11
`define NPP_CMD_COLCHG 8'h85
`define NPP_CMD_STATUS 8'h70
`define NPP_CMD_STATUS_ENH 8'h78

// Flash status byte bit positions
`define NPP_ST_FAIL 0
`define NPP_ST_CACHED_OP_ERROR_FLAG 1
`define NPP_ST_ARRAY_IDLE 5
`define NPP_ST_RDY 6

// Cycle counts and the last page of a block
`define NPP_ADDR_CYCLES 3'h5
`define NPP_ROW_CYCLES 3'h3
`define NPP_LAST_PAGE 6'h3F

// Wishbone register offsets (byte addresses)
`define NPP_REG_CTRL 4'h0
`define NPP_REG_ADDR 4'h4
`define NPP_REG_DATA 4'h8
`define NPP_REG_STAT 4'hC

// Control register fields
`define NPP_CTRL_GO 0
`define NPP_CTRL_OP_LSB 1
`define NPP_CTRL_ENH 3
`define NPP_CTRL_LEN_LSB 4
`define NPP_CTRL_LUN_LSB 16

// Status register fields
`define NPP_STAT_BUSY 0
`define NPP_STAT_DONE 1
`define NPP_STAT_FLASH_LSB 8
`define NPP_STAT_ORDER_ERR 16

// Pin timing: half period of a write or read strobe, in core_clk cycles
`define NPP_STROBE_NS 30
`define NPP_CLK_NS 20
`define NPP_STROBE_CYC (((`NPP_STROBE_NS) + (`NPP_CLK_NS) - 1) / (`NPP_CLK_NS))

`endif

// file: include/npp_pkg.sv
package npp_pkg;

  typedef enum logic [1:0] {
    NPP_OP_PLAIN = 2'h0,
    NPP_OP_CACHE = 2'h1,
    NPP_OP_QUEUE = 2'h2,
    NPP_OP_POLL = 2'h3
  } npp_op_t;

  // One bus cycle on the flash pins
  typedef struct packed {
    logic cle;
    logic ale;
    logic rd;
    logic [7:0] data;
  } npp_cycle_t;

  // Flash pins driven by the controller
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic [7:0] io_out;
    logic io_oe;
  } npp_pins_t;

endpackage

// file: core/npp_strobe.sv
`timescale 1ns/1ps
`include "npp_params.svh"

// Drives one write or read cycle on the flash pins, strobe low then high
module npp_strobe
  import npp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Cycle request
  input wire logic req_valid,
  input wire npp_cycle_t req,
  output logic req_ready,
  // Result
  output logic done,
  output logic [7:0] rd_data,
  // Pins
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in_sync
);

  typedef enum logic [2:0] {
    NPP_SB_IDLE = 3'b001,
    NPP_SB_LOW = 3'b010,
    NPP_SB_HIGH = 3'b100
  } npp_sb_state_t;

  npp_sb_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  npp_cycle_t cur_reg, cur_next;
  logic [7:0] rd_reg, rd_next;
  logic done_reg, done_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cur_next = cur_reg;
    rd_next = rd_reg;
    done_next = 1'b0;
    unique case (state_reg)
      NPP_SB_IDLE: begin
        if (req_valid) begin
          cur_next = req;
          cnt_next = 4'(`NPP_STROBE_CYC);
          state_next = NPP_SB_LOW;
        end
      end
      NPP_SB_LOW: begin
        if (cnt_reg == 4'h1) begin
          cnt_next = 4'(`NPP_STROBE_CYC);
          state_next = NPP_SB_HIGH;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      NPP_SB_HIGH: begin
        if (cnt_reg == 4'h1) begin
          // Two synchroniser stages delay the pins, so the byte driven in the
          // low phase reaches io_in_sync only during the high phase
          if (cur_reg.rd) begin
            rd_next = io_in_sync;
          end
          done_next = 1'b1;
          state_next = NPP_SB_IDLE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= NPP_SB_IDLE;
      cnt_reg <= 4'h0;
      cur_reg <= '0;
      rd_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cur_reg <= cur_next;
      rd_reg <= rd_next;
      done_reg <= done_next;
    end
  end

  assign req_ready = (state_reg == NPP_SB_IDLE);
  assign done = done_reg;
  assign rd_data = rd_reg;
  assign cle = cur_reg.cle;
  assign ale = cur_reg.ale;
  assign we_n = !((state_reg == NPP_SB_LOW) && !cur_reg.rd);
  assign re_n = !((state_reg == NPP_SB_LOW) && cur_reg.rd);
  assign io_out = cur_reg.data;
  assign io_oe = (state_reg != NPP_SB_IDLE) && !cur_reg.rd;

endmodule

// file: core/npp_host.sv
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "npp_params.svh"

module npp_host
  import npp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Flash pins
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic rb_n
);

  typedef enum logic [7:0] {
    NPP_IDLE = 8'b00000001,
    NPP_SETUP = 8'b00000010,
    NPP_ADDR = 8'b00000100,
    NPP_DATA = 8'b00001000,
    NPP_CONF = 8'b00010000,
    NPP_WAIT = 8'b00100000,
    NPP_STCMD = 8'b01000000,
    NPP_STRD = 8'b10000000
  } npp_state_t;

  // Pin synchronisers
  logic [7:0] io_s1_reg, io_s2_reg;
  logic rb_s1_reg, rb_s2_reg;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      io_s1_reg <= 8'h00;
      io_s2_reg <= 8'h00;
      rb_s1_reg <= 1'b0;
      rb_s2_reg <= 1'b0;
    end else begin
      io_s1_reg <= io_in;
      io_s2_reg <= io_s1_reg;
      rb_s1_reg <= rb_n;
      rb_s2_reg <= rb_s1_reg;
    end
  end

  npp_state_t state_reg, state_next;
  npp_op_t op_reg, op_next;
  logic [12:0] len_reg, len_next;
  logic [12:0] idx_reg, idx_next;
  logic [2:0] acnt_reg, acnt_next;
  logic [39:0] addr_reg, addr_next;
  logic [7:0] data_reg, data_next;
  logic data_full_reg, data_full_next;
  logic enh_reg, enh_next;
  logic [2:0] lun_reg, lun_next;
  logic [7:0] flash_st_reg, flash_st_next;
  logic done_reg, done_next;
  logic order_err_reg, order_err_next;
  logic [16:0] last_row_reg, last_row_next;
  logic last_valid_reg, last_valid_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;

  npp_cycle_t cyc;
  logic cyc_valid, cyc_ready, cyc_done;
  logic [7:0] rd_byte;

  npp_strobe u_strobe (
    .core_clk(core_clk),
    .nrst(nrst),
    .req_valid(cyc_valid),
    .req(cyc),
    .req_ready(cyc_ready),
    .done(cyc_done),
    .rd_data(rd_byte),
    .cle(cle),
    .ale(ale),
    .we_n(we_n),
    .re_n(re_n),
    .io_out(io_out),
    .io_oe(io_oe),
    .io_in_sync(io_s2_reg)
  );

  // Row bits 32:16 of the address: page in the low 6 bits
  logic [16:0] row;
  logic wb_req, busy;
  logic [7:0] confirm_cmd;
  logic issued;
  logic [2:0] abyte;
  assign row = addr_reg[32:16];
  // Status row cycles 5 to 7 send address bytes 2 to 4
  assign abyte = (acnt_reg >= 3'h5) ? (acnt_reg - 3'h3) : acnt_reg;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign busy = (state_reg != NPP_IDLE);
  assign issued = cyc_valid && cyc_ready;

  always_comb begin
    unique case (op_reg)
      NPP_OP_CACHE: confirm_cmd = `NPP_CMD_CACHE;
      NPP_OP_QUEUE: confirm_cmd = `NPP_CMD_QUEUE;
      default: confirm_cmd = `NPP_CMD_CONFIRM;
    endcase
  end

  always_comb begin
    cyc = '0;
    cyc_valid = 1'b0;
    unique case (state_reg)
      NPP_SETUP: begin
        cyc_valid = 1'b1;
        cyc.cle = 1'b1;
        cyc.data = `NPP_CMD_SETUP;
      end
      NPP_ADDR: begin
        cyc_valid = 1'b1;
        cyc.ale = 1'b1;
        cyc.data = addr_reg[8 * abyte +: 8];
      end
      NPP_DATA: begin
        // Streaming stalls here until software supplies the next byte
        cyc_valid = data_full_reg;
        cyc.data = data_reg;
      end
      NPP_CONF: begin
        cyc_valid = 1'b1;
        cyc.cle = 1'b1;
        cyc.data = confirm_cmd;
      end
      NPP_STCMD: begin
        cyc_valid = 1'b1;
        cyc.cle = 1'b1;
        // Enhanced status selects one die and avoids bus contention
        cyc.data = enh_reg ? `NPP_CMD_STATUS_ENH : `NPP_CMD_STATUS;
      end
      NPP_STRD: begin
        cyc_valid = (acnt_reg == 3'h0);
        cyc.rd = 1'b1;
      end
      default: begin
        cyc_valid = 1'b0;
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    len_next = len_reg;
    idx_next = idx_reg;
    acnt_next = acnt_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    data_full_next = data_full_reg;
    enh_next = enh_reg;
    lun_next = lun_reg;
    flash_st_next = flash_st_reg;
    done_next = done_reg;
    order_err_next = order_err_reg;
    last_row_next = last_row_reg;
    last_valid_next = last_valid_reg;
    ack_next = wb_req;
    rdat_next = 32'h0000_0000;

    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `NPP_REG_CTRL: rdat_next = {13'h0, lun_reg, len_reg[11:0], enh_reg, op_reg, busy};
        `NPP_REG_ADDR: rdat_next = addr_reg[31:0];
        `NPP_REG_DATA: rdat_next = {24'h0, addr_reg[39:32]};
        `NPP_REG_STAT: rdat_next = {15'h0, order_err_reg, flash_st_reg, 6'h0, done_reg,
                                    busy};
        default: rdat_next = 32'h0000_0000;
      endcase
    end

    if (wb_req && wb_we_i && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        `NPP_REG_CTRL: begin
          if (!busy && wb_dat_i[`NPP_CTRL_GO]) begin
            op_next = npp_op_t'(wb_dat_i[`NPP_CTRL_OP_LSB +: 2]);
            len_next = wb_dat_i[`NPP_CTRL_LEN_LSB +: 13];
            enh_next = wb_dat_i[`NPP_CTRL_ENH];
            lun_next = wb_dat_i[`NPP_CTRL_LUN_LSB +: 3];
            done_next = 1'b0;
            idx_next = 13'h0;
            acnt_next = 3'h0;
            state_next = (wb_dat_i[`NPP_CTRL_OP_LSB +: 2] == NPP_OP_POLL) ?
                         NPP_STCMD : NPP_SETUP;
          end
        end
        `NPP_REG_ADDR: if (!busy) addr_next[31:0] = wb_dat_i;
        `NPP_REG_DATA: begin
          if (state_reg == NPP_DATA && !data_full_reg) begin
            data_next = wb_dat_i[7:0];
            data_full_next = 1'b1;
          end else if (!busy) begin
            addr_next[39:32] = wb_dat_i[7:0];
          end
        end
        `NPP_REG_STAT: begin
          // Write one to clear; a new order fault in this cycle wins
          if (wb_dat_i[`NPP_STAT_DONE]) done_next = 1'b0;
          if (wb_sel_i[2] && wb_dat_i[`NPP_STAT_ORDER_ERR]) order_err_next = 1'b0;
        end
        default: ;
      endcase
    end

    unique case (state_reg)
      NPP_IDLE: ;
      NPP_SETUP: if (issued) begin
        // Flag pages out of ascending order within a block
        if (last_valid_reg && row[16:6] == last_row_reg[16:6] &&
            row[5:0] <= last_row_reg[5:0]) begin
          order_err_next = 1'b1;
        end
        last_row_next = row;
        last_valid_next = (row[5:0] != `NPP_LAST_PAGE);
        acnt_next = 3'h0;
        state_next = NPP_ADDR;
      end
      NPP_ADDR: if (issued) begin
        if (acnt_reg == `NPP_ADDR_CYCLES - 3'h1) begin
          state_next = (len_reg == 13'h0) ? NPP_CONF : NPP_DATA;
        end else begin
          acnt_next = acnt_reg + 3'h1;
        end
      end
      NPP_DATA: if (issued) begin
        data_full_next = 1'b0;
        idx_next = idx_reg + 13'h1;
        if (idx_reg + 13'h1 == len_reg) state_next = NPP_CONF;
      end
      NPP_CONF: if (issued) begin
        acnt_next = 3'h0;
        state_next = NPP_WAIT;
      end
      NPP_WAIT: begin
        // Only status traffic while the die is fully busy
        if (rb_s2_reg) state_next = NPP_STCMD;
      end
      NPP_STCMD: if (issued) begin
        // Enhanced status carries the row address selecting the die
        state_next = enh_reg ? NPP_ADDR : NPP_STRD;
        acnt_next = enh_reg ? 3'h5 : 3'h0;
      end
      NPP_STRD: begin
        // acnt marks a read in flight, so the done of the command or address
        // cycle before it is never taken as status
        if (issued) acnt_next = 3'h1;
        if (cyc_done && acnt_reg == 3'h1) begin
          flash_st_next = rd_byte;
          if (!rd_byte[`NPP_ST_RDY]) begin
            acnt_next = 3'h0;
          end else if (op_reg == NPP_OP_POLL && !rd_byte[`NPP_ST_ARRAY_IDLE]) begin
            acnt_next = 3'h0;
          end else begin
            // Fail bits now describe this and earlier cached operations
            done_next = 1'b1;
            state_next = NPP_IDLE;
          end
        end
      end
      default: state_next = NPP_IDLE;
    endcase

    // Enhanced status row cycles reuse the address path
    if (state_reg == NPP_ADDR && acnt_reg >= 3'h5 && issued) begin
      if (acnt_reg == 3'h5 + `NPP_ROW_CYCLES - 3'h1) begin
        acnt_next = 3'h0;
        state_next = NPP_STRD;
      end else begin
        acnt_next = acnt_reg + 3'h1;
        state_next = NPP_ADDR;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= NPP_IDLE;
      op_reg <= NPP_OP_PLAIN;
      len_reg <= 13'h0;
      idx_reg <= 13'h0;
      acnt_reg <= 3'h0;
      addr_reg <= 40'h00_0000_0000;
      data_reg <= 8'h00;
      data_full_reg <= 1'b0;
      enh_reg <= 1'b0;
      lun_reg <= 3'h0;
      flash_st_reg <= 8'h00;
      done_reg <= 1'b0;
      order_err_reg <= 1'b0;
      last_row_reg <= 17'h0;
      last_valid_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      len_reg <= len_next;
      idx_reg <= idx_next;
      acnt_reg <= acnt_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      data_full_reg <= data_full_next;
      enh_reg <= enh_next;
      lun_reg <= lun_next;
      flash_st_reg <= flash_st_next;
      done_reg <= done_next;
      order_err_reg <= order_err_next;
      last_row_reg <= last_row_next;
      last_valid_reg <= last_valid_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign ce_n = (state_reg == NPP_IDLE);
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

endmodule

// file: dv/npp_host_sva.sv
`timescale 1ns/1ps
`include "npp_params.svh"
module npp_host_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Flash pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic [7:0] io_out,
  input wire logic io_oe,
  input wire logic rb_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow request by one cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_WE_LOW_TWO: assert property ($fell(we_n) |=> !we_n ##1 we_n)
    else $error("write strobe low time wrong");
  AST_WE_HIGH_TWO: assert property ($rose(we_n) |=> we_n)
    else $error("write strobe high time too short");
  AST_RE_LOW_TWO: assert property ($fell(re_n) |=> !re_n ##1 re_n)
    else $error("read strobe low time wrong");
  AST_WRITE_CYCLE: assert property (!we_n |-> !(cle && ale) && io_oe && !ce_n)
    else $error("write cycle with bad qualifiers");
  AST_READ_RELEASED: assert property (!re_n |-> !io_oe && we_n && !cle && !ale && !ce_n)
    else $error("bus driven during a read");
  // Sync delay of rb_n gives the controller two cycles of grace
  AST_STATUS_ONLY_BUSY: assert property ($fell(we_n) && !rb_n && $past(!rb_n, 2) |->
    cle && (io_out == `NPP_CMD_STATUS || io_out == `NPP_CMD_STATUS_ENH))
    else $error("non-status cycle while die busy");
endmodule
bind npp_host npp_host_sva chk (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
  .re_n(re_n), .io_out(io_out), .io_oe(io_oe), .rb_n(rb_n));

// file: dv/npp_die_model.sv
`timescale 1ns/1ps
module npp_die_model #(
  parameter int PROG_CYC = 40,
  parameter int CBSY_CYC = 12,
  parameter int DBSY_CYC = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Controller pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic [7:0] io_out,
  // Injected cached-program error
  input wire logic err_en,
  // Die outputs
  output logic [7:0] io_die,
  output logic rb_n
);
  logic we_d;
  logic stat_mode;
  logic [7:0] junk;
  logic [7:0] stat;
  int busy;
  int abusy;
  assign rb_n = (busy == 0);
  assign stat = {1'b0, rb_n, rb_n && abusy == 0, 3'h0, err_en && rb_n && abusy != 0, 1'b0};
  // A released bus keeps changing so no stale status can be mistaken for data
  assign io_die = (stat_mode && !re_n && !ce_n) ? stat : junk;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      we_d <= 1'b1;
      stat_mode <= 1'b0;
      junk <= 8'hA5;
      busy <= 0;
      abusy <= 0;
    end else begin
      we_d <= we_n;
      junk <= ~junk + 8'h1;
      if (busy != 0) busy <= busy - 1;
      else if (abusy != 0) abusy <= abusy - 1;
      if (we_n && !we_d && !ce_n && cle) begin
        stat_mode <= (io_out == 8'h70) || (io_out == 8'h78);
        // Setup is accepted in any ready state, array busy or not
        case (io_out)
          8'h10: begin
            busy <= PROG_CYC + abusy;
            abusy <= 0;
          end
          8'h15: begin
            busy <= CBSY_CYC + abusy;
            abusy <= PROG_CYC;
          end
          // The model keeps no cache contents, so setup has nothing to clear
          8'h80: ;
          8'h11: busy <= DBSY_CYC;
          default: ;
        endcase
      end
    end
  end
endmodule

// file: dv/tb.sv
`timescale 1ns/1ps
`include "npp_params.svh"
module tb;
  import npp_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_adr = 4'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_q;
  logic wb_ack, ce_n, cle, ale, we_n, re_n, io_oe, rb_n, we_d;
  logic err_en = 1'b0;
  logic [7:0] io_out, io_die, io_bus;
  logic [9:0] log_q[$];
  int fails = 0;
  int num_checks = 0;
  always #10 core_clk = ~core_clk;
  assign io_bus = io_oe ? io_out : io_die;
  npp_host dut (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q),
    .wb_ack_o(wb_ack), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_bus), .rb_n(rb_n));
  npp_die_model die (.core_clk(core_clk), .nrst(nrst), .ce_n(ce_n), .cle(cle), .we_n(we_n),
    .re_n(re_n), .io_out(io_out), .err_en(err_en), .io_die(io_die), .rb_n(rb_n));
  // Each write cycle on the pins, logged once its strobe has risen
  always @(posedge core_clk) begin
    we_d <= we_n;
    if (!ce_n && we_n && we_d === 1'b0) log_q.push_back({cle, ale, io_out});
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] d,
                         output logic [31:0] q);
    int n;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hF;
    wb_dat <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (wb_ack !== 1'b1) fails++;
    q = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] adr, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, adr, d, q);
  endtask
  task automatic rd(input logic [3:0] adr, output logic [31:0] q);
    wb_xfer(1'b0, adr, 32'h0, q);
  endtask
  // One operation end to end; the pin log is compared with the expected cycle order
  task automatic run(input logic [1:0] op, input logic enh, input int len,
                     input logic [5:0] page, input logic [7:0] conf, input logic [31:0] exp_stat);
    logic [39:0] a;
    logic [9:0] e[$];
    logic [31:0] q;
    int n;
    a = {16'h0, 2'h0, page, 16'h0040};
    wr(`NPP_REG_STAT, 32'h2);
    log_q.delete();
    wr(`NPP_REG_ADDR, a[31:0]);
    wr(`NPP_REG_DATA, {24'h0, a[39:32]});
    wr(`NPP_REG_CTRL, {16'h0, 12'(len), enh, op, 1'b1});
    if (op != 2'h3) begin
      e.push_back({2'b10, `NPP_CMD_SETUP});
      for (int i = 0; i < 5; i++) e.push_back({2'b01, a[8*i +: 8]});
      for (int i = 0; i < len; i++) begin
        n = 0;
        while (log_q.size() < 6 + i && n < 500) begin
          @(posedge core_clk);
          n++;
        end
        wr(`NPP_REG_DATA, 32'(8'h30 + i));
        e.push_back({2'b00, 8'(8'h30 + i)});
      end
      e.push_back({2'b10, conf});
    end
    e.push_back({2'b10, enh ? `NPP_CMD_STATUS_ENH : `NPP_CMD_STATUS});
    if (enh) for (int i = 2; i < 5; i++) e.push_back({2'b01, a[8*i +: 8]});
    n = 0;
    do begin
      rd(`NPP_REG_STAT, q);
      n++;
    end while (q[1] !== 1'b1 && n < 2000);
    check(q, exp_stat);
    check(32'(log_q.size() >= e.size()), 32'h1);
    for (int i = 0; i < e.size(); i++) check(32'(log_q[i]), 32'(e[i]));
  endtask
  task automatic t_reset();
    logic [31:0] q;
    rd(`NPP_REG_STAT, q);
    check(q, 32'h0);
    wr(4'h1, 32'hFFFF_FFFF);
    rd(4'h1, q);
    check(q, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_plain();
    logic [31:0] q;
    run(2'h0, 1'b0, 2, 6'h01, `NPP_CMD_CONFIRM, 32'h0000_6002);
    rd(`NPP_REG_CTRL, q);
    check(q, 32'h0000_0020);
    rd(`NPP_REG_ADDR, q);
    check(q, 32'h0001_0040);
    wr(`NPP_REG_STAT, 32'h2);
    rd(`NPP_REG_STAT, q);
    check(q, 32'h0000_6000);
    $display("test plain done");
  endtask
  task automatic t_cache();
    err_en <= 1'b1;
    // Ends ready with the array still busy, so the cached error bit is seen
    run(2'h1, 1'b0, 1, 6'h02, `NPP_CMD_CACHE, 32'h0000_4202);
    run(2'h0, 1'b0, 1, 6'h03, `NPP_CMD_CONFIRM, 32'h0000_6002);
    run(2'h1, 1'b0, 1, 6'h04, `NPP_CMD_CACHE, 32'h0000_4202);
    run(2'h3, 1'b0, 0, 6'h04, 8'h00, 32'h0000_6002);
    err_en <= 1'b0;
    $display("test cache done");
  endtask
  task automatic t_queue_order();
    logic [31:0] q;
    run(2'h2, 1'b1, 1, 6'h05, `NPP_CMD_QUEUE, 32'h0000_6002);
    // Page 0 after page 5 in the same block raises the order flag
    run(2'h0, 1'b0, 1, 6'h00, `NPP_CMD_CONFIRM, 32'h0001_6002);
    wr(`NPP_REG_STAT, 32'h0001_0000);
    rd(`NPP_REG_STAT, q);
    check(q, 32'h0000_6002);
    $display("test queue and order done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_plain();
    t_cache();
    t_queue_order();
    conclude();
  end
  initial begin
    #400000;
    fails++;
    conclude();
  end
endmodule
